/* File: crta_pkg.sv */
// Constants, field layouts and types of the CRT attribute logic.
`default_nettype none

package crta_pkg;

  // Widths and depths.
  localparam int CRTA_NBUF    = 2;
  localparam int CRTA_CHAR_W  = 8;
  localparam int CRTA_FIFO_W  = 7;
  localparam int CRTA_FIFO_D  = 16;
  localparam int CRTA_BLINK_W = 5;

  // Character code fields: bit 7 marks an attribute, bit 6 picks the kind.
  localparam int CRTA_MARK_BIT = 7;
  localparam int CRTA_KIND_BIT = 6;
  localparam logic [3:0] CRTA_CATTR_SPECIAL = 4'hc;

  // Special control function field.
  localparam logic [1:0] CRTA_SS_EOR      = 2'h0;
  localparam logic [1:0] CRTA_SS_EOR_STOP = 2'h1;
  localparam logic [1:0] CRTA_SS_EOS      = 2'h2;
  localparam logic [1:0] CRTA_SS_EOS_STOP = 2'h3;

  // Line regions of a character row.
  localparam logic [1:0] CRTA_REG_ABOVE = 2'h0;
  localparam logic [1:0] CRTA_REG_UNDER = 2'h1;
  localparam logic [1:0] CRTA_REG_BELOW = 2'h2;

  // Field attribute bits in code order.
  typedef struct packed {
    logic       ul;
    logic       reverse_video_out;
    logic [1:0] gpa;
    logic       blink;
    logic       highlight_out;
  } crta_fattr_type;

  localparam crta_fattr_type CRTA_FATTR_RST = 6'h00;

  // Line attribute outputs for one region.
  typedef struct packed {
    logic la1;
    logic la0;
    logic video_suppress_out;
    logic light_enable_out;
  } crta_lattr_type;

  // Per code: above, underline and below nibbles, each {la1,la0,vsp,light_enable_out}.
  localparam logic [15:0][11:0] CRTA_CATTR_TBL = {
    12'h000, 12'h000, 12'h000, 12'h222, 12'h000, 12'h414, 12'h444, 12'h212,
    12'h412, 12'h484, 12'h4c4, 12'h214, 12'h4c2, 12'h482, 12'h2c4, 12'h284
  };

  typedef enum logic [1:0] {
    CRTA_SHOW,
    CRTA_ROW_OFF,
    CRTA_SCREEN_OFF
  } crta_state_type;

endpackage : crta_pkg

`default_nettype wire

/* File: crta_attr_logic.sv */
// Attribute and special code decoding with per-buffer field attribute FIFOs.
`default_nettype none
`timescale 1ns/1ps

module crta_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             i_clk_sys,
  input  wire logic             i_nrst,
  input  wire logic             i_flush,
  // Filling side.
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Draining side.
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              full  = (wr_q[AW] != rd_q[AW]) &&
                            (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire              empty = (wr_q == rd_q);
  wire              push  = i_in_valid && !full;
  wire              pop   = i_out_ready && !empty;

  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (i_flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= push ? wr_q + 1'b1 : wr_q;
      rd_q <= pop ? rd_q + 1'b1 : rd_q;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= i_in_data;
    end
  end
endmodule : crta_fifo

module crta_attr_logic
  import crta_pkg::*;
(
  // Clock and reset.
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_nrst,
  // Configuration and timing.
  input  wire logic                   i_invisible_mode,
  input  wire logic                   i_vrtc,
  input  wire logic                   i_row_end,
  input  wire logic                   i_line_end,
  input  wire logic [1:0]             i_line_region,
  // DMA fill into the row buffers.
  input  wire logic                   i_fill_valid,
  output logic                        o_fill_ready,
  input  wire logic [CRTA_CHAR_W-1:0] i_fill_char,
  input  wire logic                   i_fill_buf,
  input  wire logic                   i_fill_last,
  output logic                        o_buf_wr_valid,
  output logic [CRTA_CHAR_W-1:0]      o_buf_wr_char,
  output logic                        o_buf_wr_sel,
  output logic                        o_dma_row_stop,
  output logic                        o_dma_frame_stop,
  // Display stream out of the row buffers.
  input  wire logic                   i_disp_valid,
  input  wire logic [CRTA_CHAR_W-1:0] i_disp_char,
  input  wire logic                   i_disp_buf,
  output logic [CRTA_FIFO_W-1:0]      o_char_code_out,
  output logic                        o_video_suppress_out,
  output logic                        o_highlight_out,
  output logic                        o_reverse_video_out,
  output logic                        o_light_enable_out,
  output logic [1:0]                  o_general_attr_out,
  output logic                        o_line_attr_code_bit0,
  output logic                        o_line_attr_code_bit1,
  // Status.
  input  wire logic                   i_overrun_clr,
  output logic                        o_fifo_overrun
);

  function automatic logic is_field(input logic [CRTA_CHAR_W-1:0] c);
    is_field = c[CRTA_MARK_BIT] && !c[CRTA_KIND_BIT];
  endfunction : is_field

  function automatic logic is_special(input logic [CRTA_CHAR_W-1:0] c);
    is_special = c[CRTA_MARK_BIT] && c[CRTA_KIND_BIT] &&
                 (c[5:2] == CRTA_CATTR_SPECIAL);
  endfunction : is_special

  // Fill side: one holding stage in front of the buffer and the FIFOs.
  logic                   hold_valid_q;
  logic [CRTA_CHAR_W-1:0] hold_char_q;
  logic                   hold_fifo_q;
  logic                   hold_buf_q;
  logic                   route_q;
  logic                   stop_pend_q;
  logic                   stop_frame_q;
  logic                   fill_ready_q;
  logic                   buf_wr_valid_q;
  logic [CRTA_CHAR_W-1:0] buf_wr_char_q;
  logic                   buf_wr_sel_q;
  logic                   row_stop_q;
  logic                   frame_stop_q;
  logic                   overrun_q;

  logic [CRTA_NBUF-1:0]   ff_in_valid;
  logic [CRTA_NBUF-1:0]   ff_in_ready;
  logic [CRTA_NBUF-1:0]   ff_out_valid;
  logic [CRTA_NBUF-1:0]   ff_out_ready;
  logic [CRTA_FIFO_W-1:0] ff_out_data [CRTA_NBUF];

  wire accept     = i_fill_valid && fill_ready_q;
  wire hold_stuck = hold_fifo_q && !ff_in_ready[hold_buf_q];
  wire drain      = hold_valid_q && !hold_stuck;
  wire drop       = hold_valid_q && hold_stuck;
  wire to_fifo    = route_q && i_invisible_mode;
  wire fill_spec  = is_special(i_fill_char);
  wire [1:0] fss  = i_fill_char[1:0];
  wire stop_code  = fill_spec && !to_fifo &&
                    (fss == CRTA_SS_EOR_STOP || fss == CRTA_SS_EOS_STOP);
  wire stop_now   = accept && ((stop_code && i_fill_last) || stop_pend_q);
  wire stop_frame = stop_pend_q ? stop_frame_q
                                : (fss == CRTA_SS_EOS_STOP);
  wire hold_vd    = accept || (hold_valid_q && !drain);
  wire hold_fd    = accept ? to_fifo : hold_fifo_q;
  wire ready_d    = !(hold_vd && hold_fd) && !stop_now &&
                    !(row_stop_q || frame_stop_q);

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      hold_valid_q <= 1'b0;
      hold_char_q  <= '0;
      hold_fifo_q  <= 1'b0;
      hold_buf_q   <= 1'b0;
      fill_ready_q <= 1'b0;
    end else begin
      hold_valid_q <= hold_vd;
      hold_fifo_q  <= hold_fd;
      fill_ready_q <= ready_d && !i_vrtc;
      if (accept) begin
        hold_char_q <= i_fill_char;
        hold_buf_q  <= i_fill_buf;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      route_q <= 1'b0;
    end else if (i_vrtc) begin
      route_q <= 1'b0;
    end else if (accept) begin
      route_q <= !to_fifo && is_field(i_fill_char) && i_invisible_mode;
    end
  end

  // A stop code that is not the last character waits for one more fetch.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      stop_pend_q  <= 1'b0;
      stop_frame_q <= 1'b0;
      row_stop_q   <= 1'b0;
      frame_stop_q <= 1'b0;
    end else if (i_vrtc) begin
      stop_pend_q  <= 1'b0;
      stop_frame_q <= 1'b0;
      row_stop_q   <= 1'b0;
      frame_stop_q <= 1'b0;
    end else begin
      if (accept && stop_code && !i_fill_last) begin
        stop_pend_q  <= 1'b1;
        stop_frame_q <= (fss == CRTA_SS_EOS_STOP);
      end else if (stop_now) begin
        stop_pend_q  <= 1'b0;
      end
      if (stop_now && !stop_frame) begin
        row_stop_q <= 1'b1;
      end else if (i_row_end) begin
        row_stop_q <= 1'b0;
      end
      if (stop_now && stop_frame) begin
        frame_stop_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      buf_wr_valid_q <= 1'b0;
      buf_wr_char_q  <= '0;
      buf_wr_sel_q   <= 1'b0;
    end else begin
      buf_wr_valid_q <= drain && !hold_fifo_q;
      buf_wr_char_q  <= hold_char_q;
      buf_wr_sel_q   <= hold_buf_q;
    end
  end

  // Overrun is sticky; a new loss wins over a clear in the same cycle.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      overrun_q <= 1'b0;
    end else begin
      overrun_q <= drop || (overrun_q && !i_overrun_clr);
    end
  end

  // Display side.
  crta_state_type         state_q;
  crta_state_type         state_d;
  crta_fattr_type         fattr_q;
  crta_fattr_type         fattr_d;
  logic                   vrtc_q;
  logic [CRTA_BLINK_W-1:0] frame_cnt_q;

  wire [CRTA_CHAR_W-1:0] c       = i_disp_char;
  wire                   d_field = i_disp_valid && is_field(c);
  wire                   d_spec  = i_disp_valid && is_special(c);
  wire                   d_cattr = i_disp_valid && c[CRTA_MARK_BIT] &&
                                   c[CRTA_KIND_BIT] && !is_special(c);
  wire                   d_eos   = d_spec && c[1];
  wire                   showing = (state_q == CRTA_SHOW);
  wire                   blink_ph = frame_cnt_q[CRTA_BLINK_W-1];
  wire                   pop_disp = d_field && showing && i_invisible_mode;
  wire crta_fattr_type   new_fa  = c[5:0];
  wire [11:0]            tbl_row = CRTA_CATTR_TBL[c[5:2]];
  wire crta_lattr_type   lat     =
    (i_line_region == CRTA_REG_ABOVE) ? tbl_row[11:8] :
    (i_line_region == CRTA_REG_UNDER) ? tbl_row[7:4]  :
    (i_line_region == CRTA_REG_BELOW) ? tbl_row[3:0]  : 4'h0;

  // Blink of the field applies to reversed characters when both are set.
  function automatic logic [1:0] fa_blink(input crta_fattr_type f,
                                          input logic ph);
    fa_blink = {f.blink && f.reverse_video_out && ph, f.blink && !f.reverse_video_out && ph};
  endfunction : fa_blink

  always_comb begin
    state_d = state_q;
    if (d_spec && showing) begin
      state_d = c[1] ? CRTA_SCREEN_OFF : CRTA_ROW_OFF;
    end else if (d_eos && state_q == CRTA_ROW_OFF) begin
      state_d = CRTA_SCREEN_OFF;
    end else if (i_line_end && state_q == CRTA_ROW_OFF) begin
      state_d = CRTA_SHOW;
    end
  end

  assign fattr_d = (d_field && showing) ? new_fa : fattr_q;

  generate
    for (genvar b = 0; b < CRTA_NBUF; b++) begin : g_fifo
      assign ff_in_valid[b]  = hold_valid_q && hold_fifo_q &&
                               (hold_buf_q == b);
      assign ff_out_ready[b] = (pop_disp && (i_disp_buf == b)) ||
                               (drop && (hold_buf_q == b));
      crta_fifo #(
        .WIDTH (CRTA_FIFO_W),
        .DEPTH (CRTA_FIFO_D)
      ) u_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_nrst      (i_nrst),
        .i_flush     (i_vrtc),
        .i_in_valid  (ff_in_valid[b]),
        .o_in_ready  (ff_in_ready[b]),
        .i_in_data   (hold_char_q[CRTA_FIFO_W-1:0]),
        .o_out_valid (ff_out_valid[b]),
        .i_out_ready (ff_out_ready[b]),
        .o_out_data  (ff_out_data[b])
      );
    end
  endgenerate

  // Output selection.
  logic [CRTA_FIFO_W-1:0] cc_d;
  logic                   vsp_d;
  logic                   highlight_out_d;
  logic                   rvv_d;
  logic                   light_enable_out_d;
  logic [1:0]             gpa_d;
  logic                   la0_d;
  logic                   la1_d;
  logic [1:0]             bl;

  always_comb begin
    bl     = fa_blink(fattr_q, blink_ph);
    cc_d   = c[CRTA_FIFO_W-1:0];
    vsp_d  = bl[0];
    highlight_out_d = fattr_q.highlight_out;
    rvv_d  = fattr_q.reverse_video_out && !bl[1];
    light_enable_out_d = fattr_q.ul;
    gpa_d  = fattr_q.gpa;
    la0_d  = 1'b0;
    la1_d  = 1'b0;
    if (!i_disp_valid || !showing || d_spec) begin
      vsp_d  = 1'b1;
      highlight_out_d = 1'b0;
      rvv_d  = 1'b0;
      light_enable_out_d = 1'b0;
      gpa_d  = 2'h0;
    end else if (d_field && i_invisible_mode) begin
      bl     = fa_blink(new_fa, blink_ph);
      cc_d   = ff_out_valid[i_disp_buf] ? ff_out_data[i_disp_buf]
                                        : '0;
      vsp_d  = bl[0];
      highlight_out_d = new_fa.highlight_out;
      rvv_d  = new_fa.reverse_video_out && !bl[1];
      light_enable_out_d = new_fa.ul;
      gpa_d  = new_fa.gpa;
    end else if (d_field) begin
      vsp_d  = 1'b1;
    end else if (d_cattr) begin
      la1_d  = lat.la1;
      la0_d  = lat.la0;
      vsp_d  = lat.video_suppress_out || (c[1] && blink_ph);
      highlight_out_d = c[0];
      light_enable_out_d = lat.light_enable_out;
      rvv_d  = fattr_q.reverse_video_out;
      gpa_d  = fattr_q.gpa;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= CRTA_SHOW;
      fattr_q <= CRTA_FATTR_RST;
    end else if (i_vrtc) begin
      state_q <= CRTA_SHOW;
      fattr_q <= CRTA_FATTR_RST;
    end else begin
      state_q <= state_d;
      fattr_q <= fattr_d;
    end
  end

  // Frame counter paced by the start of each vertical retrace.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      vrtc_q      <= 1'b0;
      frame_cnt_q <= '0;
    end else begin
      vrtc_q      <= i_vrtc;
      frame_cnt_q <= (i_vrtc && !vrtc_q) ? frame_cnt_q + 1'b1
                                          : frame_cnt_q;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_char_code_out       <= '0;
      o_video_suppress_out  <= 1'b1;
      o_highlight_out       <= 1'b0;
      o_reverse_video_out   <= 1'b0;
      o_light_enable_out    <= 1'b0;
      o_general_attr_out    <= 2'h0;
      o_line_attr_code_bit0 <= 1'b0;
      o_line_attr_code_bit1 <= 1'b0;
    end else begin
      o_char_code_out       <= cc_d;
      o_video_suppress_out  <= vsp_d;
      o_highlight_out       <= highlight_out_d;
      o_reverse_video_out   <= rvv_d;
      o_light_enable_out    <= light_enable_out_d;
      o_general_attr_out    <= gpa_d;
      o_line_attr_code_bit0 <= la0_d;
      o_line_attr_code_bit1 <= la1_d;
    end
  end

  assign o_fill_ready     = fill_ready_q;
  assign o_buf_wr_valid   = buf_wr_valid_q;
  assign o_buf_wr_char    = buf_wr_char_q;
  assign o_buf_wr_sel     = buf_wr_sel_q;
  assign o_dma_row_stop   = row_stop_q;
  assign o_dma_frame_stop = frame_stop_q;
  assign o_fifo_overrun   = overrun_q;

endmodule : crta_attr_logic

`default_nettype wire

/* File: crta_attr_logic_asserts.sv */
// Port checker for the CRT attribute and special code logic.
`timescale 1ns/1ps
`default_nettype none
module crta_attr_logic_asserts (
  // Clock and reset.
  input wire logic       i_clk_sys,
  input wire logic       i_nrst,
  // Timing and mode.
  input wire logic       i_invisible_mode,
  input wire logic       i_vrtc,
  input wire logic       i_line_end,
  // Fill side.
  input wire logic       i_fill_valid,
  input wire logic       o_fill_ready,
  input wire logic [7:0] i_fill_char,
  input wire logic       i_fill_last,
  input wire logic       o_dma_row_stop,
  input wire logic       o_dma_frame_stop,
  // Display side.
  input wire logic       i_disp_valid,
  input wire logic [7:0] i_disp_char,
  input wire logic       o_video_suppress_out,
  input wire logic       o_highlight_out,
  input wire logic       o_light_enable_out,
  input wire logic       o_line_attr_code_bit0,
  input wire logic       o_line_attr_code_bit1,
  // Status.
  input wire logic       o_fifo_overrun,
  input wire logic       i_overrun_clr
);
  logic eos_q;
  logic row_q;
  wire  take   = i_fill_valid && o_fill_ready;
  wire  is_eos = i_disp_valid && i_disp_char[7:1] == 7'h79;
  wire  is_eor = i_disp_valid && i_disp_char[7:1] == 7'h78;
  wire  live   = !eos_q && !row_q;
  wire  cattr  = i_disp_valid && i_disp_char[7:6] == 2'h3;

  // Tracks suppression that the stream itself has asked for.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      eos_q <= 1'b0;
      row_q <= 1'b0;
    end else begin
      eos_q <= (eos_q || is_eos) && !i_vrtc;
      row_q <= (row_q || is_eor) && !i_vrtc && !i_line_end;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  property p_eor;
    row_q && !i_line_end && !i_vrtc |-> o_video_suppress_out;
  endproperty
  a_eor: assert property (p_eor) else $error("vsp low in row end");
  property p_eos;
    eos_q && !i_vrtc |-> o_video_suppress_out;
  endproperty
  a_eos: assert property (p_eos) else $error("vsp low in screen end");
  property p_blank_code;
    cattr && i_disp_char[5:2] == 4'hb && live
      |=> !o_line_attr_code_bit0 && !o_line_attr_code_bit1
          && !o_light_enable_out;
  endproperty
  a_blank_code: assert property (p_blank_code) else $error("1011 active");
  property p_highlight_out;
    cattr && i_disp_char[5:2] < 4'hc && i_disp_char[0] && live
      |=> o_highlight_out;
  endproperty
  a_highlight_out: assert property (p_highlight_out) else $error("highlight bit lost");
  property p_vis;
    i_disp_valid && i_disp_char[7:6] == 2'h2 && !i_invisible_mode
      |=> o_video_suppress_out;
  endproperty
  a_vis: assert property (p_vis) else $error("field code not blank");
  property p_rstop;
    take && i_fill_char == 8'hf1 && i_fill_last |=> o_dma_row_stop;
  endproperty
  a_rstop: assert property (p_rstop) else $error("row stop missing");
  property p_fstop;
    take && i_fill_char == 8'hf3 && i_fill_last |=> o_dma_frame_stop;
  endproperty
  a_fstop: assert property (p_fstop) else $error("frame stop missing");
  property p_late;
    take && i_fill_char == 8'hf1 && !i_fill_last && !o_dma_row_stop
      |=> !o_dma_row_stop;
  endproperty
  a_late: assert property (p_late) else $error("stop came early");
  property p_ovr;
    o_fifo_overrun && !i_overrun_clr && !i_vrtc |=> o_fifo_overrun;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun flag lost");

  c_eos: cover property (eos_q);
  c_rstop: cover property ($rose(o_dma_row_stop));
  c_ovr: cover property ($rose(o_fifo_overrun));
endmodule : crta_attr_logic_asserts

bind crta_attr_logic crta_attr_logic_asserts u_chk (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_vrtc(i_vrtc),
  .i_invisible_mode(i_invisible_mode), .i_line_end(i_line_end),
  .i_fill_valid(i_fill_valid), .o_fill_ready(o_fill_ready),
  .i_fill_char(i_fill_char), .i_fill_last(i_fill_last),
  .o_dma_row_stop(o_dma_row_stop), .o_dma_frame_stop(o_dma_frame_stop),
  .i_disp_valid(i_disp_valid), .i_disp_char(i_disp_char),
  .o_video_suppress_out(o_video_suppress_out),
  .o_highlight_out(o_highlight_out),
  .o_light_enable_out(o_light_enable_out),
  .o_line_attr_code_bit0(o_line_attr_code_bit0),
  .o_line_attr_code_bit1(o_line_attr_code_bit1),
  .o_fifo_overrun(o_fifo_overrun), .i_overrun_clr(i_overrun_clr)
);
`default_nettype wire

/* File: crta_dma_model.sv */
// DMA controller model that feeds characters into the row buffers.
`timescale 1ns/1ps
`default_nettype none
module crta_dma_model (
  // Clock and flow control.
  input  wire logic i_clk_sys,
  input  wire logic i_fill_ready,
  input  wire logic i_row_stop,
  input  wire logic i_frame_stop,
  // Fill bus.
  output logic       o_fill_valid,
  output logic [7:0] o_fill_char,
  output logic       o_fill_buf,
  output logic       o_fill_last
);
  initial begin
    o_fill_valid = 1'b0;
    o_fill_char  = 8'h00;
    o_fill_buf   = 1'b0;
    o_fill_last  = 1'b0;
  end

  // Called at a falling edge; keep holds valid for a back-to-back follower.
  task automatic send(input logic [7:0] c, input logic b, input logic l,
                      input logic keep);
    int n;
    n = 0;
    if (i_row_stop || i_frame_stop || (c[7:6] == 2'h3 && c[5:2] > 4'hc))
    begin
      o_fill_valid = 1'b0;
      return;
    end
    o_fill_valid = 1'b1;
    o_fill_char  = c;
    o_fill_buf   = b;
    o_fill_last  = l;
    while (!i_fill_ready && n < 40) begin
      @(negedge i_clk_sys);
      n++;
    end
    @(negedge i_clk_sys);
    if (!keep) begin
      o_fill_valid = 1'b0;
      o_fill_char  = ~c;
      o_fill_last  = ~l;
    end
  endtask : send
endmodule : crta_dma_model
`default_nettype wire

/* File: tb_crta_attr_logic.sv */
// Self-checking testbench of the CRT attribute and special code logic.
`timescale 1ns/1ps
`default_nettype none
module tb_crta_attr_logic;
  import crta_pkg::*;
  logic       clk, nrst, inv, vrtc, rend, lend, dv, dbuf, oclr, ph;
  logic [1:0] reg_s;
  logic [7:0] dch;
  wire        fv, fb, fl, frdy, rstop, fstop, video_suppress_out, hg, rv, lt, la0, la1;
  wire        ovr, bwv, bws;
  wire  [7:0] bwc;
  logic [8:0] bw_last;
  int         bw_n;
  wire  [7:0] fch;
  wire  [6:0] cc;
  wire  [1:0] gp;
  wire  [7:0] outs = {video_suppress_out, hg, rv, lt, gp, la1, la0};
  int         err_count, checks_done, frames;

  crta_attr_logic u_dut (
    .i_clk_sys(clk), .i_nrst(nrst), .i_invisible_mode(inv),
    .i_vrtc(vrtc), .i_row_end(rend), .i_line_end(lend),
    .i_line_region(reg_s), .i_fill_valid(fv), .o_fill_ready(frdy),
    .i_fill_char(fch), .i_fill_buf(fb), .i_fill_last(fl),
    .o_buf_wr_valid(bwv), .o_buf_wr_char(bwc), .o_buf_wr_sel(bws),
    .o_dma_row_stop(rstop), .o_dma_frame_stop(fstop),
    .i_disp_valid(dv), .i_disp_char(dch), .i_disp_buf(dbuf),
    .o_char_code_out(cc), .o_video_suppress_out(video_suppress_out),
    .o_highlight_out(hg), .o_reverse_video_out(rv),
    .o_light_enable_out(lt), .o_general_attr_out(gp),
    .o_line_attr_code_bit0(la0), .o_line_attr_code_bit1(la1),
    .i_overrun_clr(oclr), .o_fifo_overrun(ovr)
  );
  crta_dma_model u_dma (
    .i_clk_sys(clk), .i_fill_ready(frdy), .i_row_stop(rstop),
    .i_frame_stop(fstop), .o_fill_valid(fv), .o_fill_char(fch),
    .o_fill_buf(fb), .o_fill_last(fl)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Counts row buffer writes and keeps the last one with its buffer select.
  always @(posedge clk) begin
    if (nrst && bwv) begin
      bw_n    <= bw_n + 1;
      bw_last <= {bws, bwc};
    end
  end

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  // One display character; outputs for it are settled on return.
  task automatic disp(input logic [7:0] c, input logic b);
    @(negedge clk);
    dv   = 1'b1;
    dch  = c;
    dbuf = b;
    @(negedge clk);
    dv  = 1'b0;
    dch = ~c;
  endtask : disp

  task automatic strobe(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    @(negedge clk);
  endtask : strobe

  // Blink phase assumes the frame count starts from zero at reset.
  task automatic retrace();
    strobe(vrtc);
    frames++;
    ph = frames[4];
  endtask : retrace

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  initial begin
    #1_000_000;
    err_count++;
    results();
  end

  initial begin
    {nrst, inv, vrtc, rend, lend, dv, dbuf, oclr, ph} = 9'h000;
    reg_s = 2'h0;
    dch = 8'h00;
    repeat (6) @(negedge clk);
    chk_val({5'h0, video_suppress_out, frdy, hg}, 8'h04);
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    retrace();
    for (int c = 0; c < 12; c++) begin
      for (int r = 0; r < 3; r++) begin
        reg_s = r[1:0];
        disp({2'h3, c[3:0], 2'h0}, 1'b0);
        chk_val({4'h0, la1, la0, video_suppress_out, lt},
                {4'h0, CRTA_CATTR_TBL[c][4*(2-r) +: 4]});
      end
    end
    $display("test character table done");
    repeat (2) begin
      reg_s = 2'h2;
      disp(8'he7, 1'b0);
      chk_val({4'h0, video_suppress_out, hg, la1, la0}, {4'h0, ph, 3'h5});
      disp(8'h92, 1'b0);
      disp(8'h41, 1'b0);
      chk_val(outs, {2'h0, !ph, 5'h00});
      disp(8'h82, 1'b0);
      disp(8'h41, 1'b0);
      chk_val(outs, {ph, 7'h00});
      repeat (16) retrace();
    end
    reg_s = 2'h1;
    disp(8'hbd, 1'b0);
    chk_val(outs, 8'h80);
    disp(8'h41, 1'b0);
    chk_val(outs, 8'h7c);
    disp(8'he4, 1'b0);
    chk_val(outs, 8'h2d);
    disp(8'h80, 1'b0);
    chk_val({7'h0, video_suppress_out}, 8'h01);
    disp(8'h41, 1'b0);
    chk_val(outs, 8'h00);
    $display("test field attributes done");
    for (int s = 0; s < 4; s++) begin
      retrace();
      disp({6'h3c, s[1:0]}, 1'b0);
      disp(8'he4, 1'b0);
      chk_val({7'h0, video_suppress_out}, 8'h01);
      strobe(lend);
      disp(8'h41, 1'b0);
      chk_val({7'h0, video_suppress_out}, {7'h0, s[1]});
    end
    retrace();
    disp(8'hf0, 1'b0);
    disp(8'hf2, 1'b0);
    strobe(lend);
    disp(8'h41, 1'b0);
    chk_val({7'h0, video_suppress_out}, 8'h01);
    $display("test special codes done");
    retrace();
    u_dma.send(8'h41, 1'b0, 1'b0, 1'b1);
    u_dma.send(8'hf1, 1'b0, 1'b1, 1'b0);
    chk_val({5'h0, frdy, rstop, fstop}, 8'h02);
    strobe(rend);
    u_dma.send(8'hf1, 1'b0, 1'b0, 1'b1);
    chk_val({6'h0, rstop, fstop}, 8'h00);
    u_dma.send(8'h20, 1'b0, 1'b1, 1'b0);
    chk_val({6'h0, rstop, fstop}, 8'h02);
    strobe(rend);
    u_dma.send(8'hf3, 1'b1, 1'b1, 1'b0);
    strobe(rend);
    chk_val({5'h0, frdy, rstop, fstop}, 8'h01);
    chk_val(bw_n[7:0], 8'h05);
    chk_val(bw_last[7:0], 8'hf3);
    chk_val({7'h0, bw_last[8]}, 8'h01);
    $display("test dma stops done");
    inv = 1'b1;
    retrace();
    for (int k = 0; k < 17; k++) begin
      u_dma.send(8'h82, 1'b1, 1'b0, 1'b1);
      u_dma.send(8'hc0 + k[7:0], 1'b1, 1'b0, k < 16);
    end
    repeat (3) @(negedge clk);
    chk_val({7'h0, ovr}, 8'h01);
    chk_val(bw_n[7:0], 8'h16);
    chk_val(bw_last[7:0], 8'h82);
    for (int k = 1; k < 18; k++) begin
      disp(8'h90, 1'b1);
      chk_val({rv, cc}, {1'b1, k < 17 ? 7'h40 + k[6:0] : 7'h00});
    end
    strobe(oclr);
    chk_val({7'h0, ovr}, 8'h00);
    $display("test invisible fifo done");
    results();
  end
endmodule : tb_crta_attr_logic
`default_nettype wire
